// *** rtl/mbrs_slave.sv ***
// How it works
// RULE_01: packet ends after 3.5 idle byte times
// RULE_02: senders keep bytes back to back
// RULE_03: after idle, return to waiting for packets
// RULE_04: act only on own module number 1-250
// RULE_05: address 255 reserved for commissioning only
// RULE_06: bad crc: drop silently, no reply
// RULE_07: parse address, function, data, then crc
// RULE_08: support functions 03, 05, 06, 16
// RULE_09: reads return one or more 16-bit registers
// RULE_10: reads only in index 0 to 164
// RULE_11: read request: index, count, crc from master
// RULE_12: read reply: address, function, byte count, data
// RULE_13: function 05 value FF00 resets index 165-186
// RULE_14: function 05 value zero is legal, no change
// RULE_15: other 05 values or indexes raise error
// RULE_16: function 05 reply echoes index and FF00; code echoes the request value, so 0000 for value zero
// RULE_17: function 06 writes 0-30, 31-43, 71-108 only
// RULE_18: function 06 reply echoes index and value
// RULE_19: errors reply function plus 128, exception code
// RULE_20: exceptions 01 function, 02 index, 08 switch
// RULE_21: ten-bit characters at 1200 to 9600 baud
// RULE_22: function 16 writes only 31-43 or 71-108
// RULE_23: crc-16 low byte first, fields high first
// RULE_24: reply only after idle end and validation
module mbrs_slave #(
   parameter int unsigned DEAD_1200_CYC = mbrs_pkg::DEAD_1200,
   parameter int unsigned DEAD_2400_CYC = mbrs_pkg::DEAD_2400,
   parameter int unsigned DEAD_4800_CYC = mbrs_pkg::DEAD_4800,
   parameter int unsigned DEAD_9600_CYC = mbrs_pkg::DEAD_9600
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] module_num_i,
   input wire logic addr_en_pin_i,
   input wire logic [1:0] baud_sel_i,
   input wire logic [7:0] rx_data_i,
   input wire logic rx_valid_i,
   input wire logic rx_err_i,
   output logic [7:0] tx_data_o,
   output logic tx_valid_o,
   input wire logic tx_ready_i,
   output logic [15:0] rd_idx_o,
   input wire logic [15:0] rd_data_i,
   output logic wr_stb_o,
   output logic [15:0] wr_idx_o,
   output logic [15:0] wr_data_o,
   output logic clr_stb_o,
   output logic [15:0] clr_idx_o,
   output logic busy_o
);
   typedef struct packed {
      mbrs_pkg::mbrs_state_t st;
      logic [mbrs_pkg::GAP_W-1:0] gap;
      logic [mbrs_pkg::LEN_W-1:0] len;
      logic ovf;
      logic [15:0] rxcrc;
      logic [mbrs_pkg::FRM_DEPTH-1:0][7:0] fbuf;
      logic [5:0][7:0] ob;
      logic [2:0] olen;
      logic [2:0] opos;
      logic rdm;
      logic [15:0] txcrc;
      logic [15:0] ridx;
      logic [7:0] rleft;
      logic hi;
      logic [mbrs_pkg::LEN_W-1:0] k;
      logic [15:0] rd_idx;
      logic wr_stb;
      logic [15:0] wr_idx;
      logic [15:0] wr_data;
      logic clr_stb;
      logic [15:0] clr_idx;
      logic sw_s1;
      logic sw_s2;
      logic busy;
   } mbrs_slave_t;

   mbrs_slave_t q, n;
   logic [mbrs_pkg::GAP_W-1:0] dead_lim;
   logic push, fifo_ready, good, fmt_ok, exc, is_comm;
   logic [7:0] pbyte, ecode, fa, ff;
   logic [15:0] idx, val, last;

   ////////////////////////////////////////////////////////////////////////////
   // dead time in cycles for the chosen baud rate
   always_comb begin
      case (baud_sel_i) // see RULE_21
         mbrs_pkg::BSEL_1200: dead_lim = mbrs_pkg::GAP_W'(DEAD_1200_CYC);
         mbrs_pkg::BSEL_2400: dead_lim = mbrs_pkg::GAP_W'(DEAD_2400_CYC);
         mbrs_pkg::BSEL_4800: dead_lim = mbrs_pkg::GAP_W'(DEAD_4800_CYC);
         default: dead_lim = mbrs_pkg::GAP_W'(DEAD_9600_CYC);
      endcase
   end

   // request fields, two-byte fields high byte first
   assign fa = q.fbuf[0];
   assign ff = q.fbuf[1];
   assign idx = {q.fbuf[2], q.fbuf[3]}; // see RULE_07, RULE_23
   assign val = {q.fbuf[4], q.fbuf[5]};
   assign last = idx + val - 16'h0001;
   assign is_comm = (fa == mbrs_pkg::ADDR_COMM); // see RULE_05
   // own address must itself be a legal module number
   assign good = !q.ovf && (q.len >= mbrs_pkg::LEN_MIN) && (q.rxcrc == 16'h0000) // see RULE_06
      && (is_comm || (fa == module_num_i && module_num_i >= mbrs_pkg::ADDR_MIN
      && module_num_i <= mbrs_pkg::ADDR_MAX)); // see RULE_04

   ////////////////////////////////////////////////////////////////////////////
   // decode, range checks and the byte emitter
   always_comb begin
      n = q;
      n.wr_stb = 1'b0;
      n.clr_stb = 1'b0;
      n.sw_s1 = addr_en_pin_i;
      n.sw_s2 = q.sw_s1;
      push = 1'b0;
      pbyte = 8'h00;
      fmt_ok = 1'b0;
      exc = 1'b0;
      ecode = mbrs_pkg::EXC_FUNC;
      case (q.st)
         mbrs_pkg::MBRS_WAIT: begin
            if (rx_valid_i) begin
               n.gap = '0;
               if (rx_err_i || q.len == mbrs_pkg::LEN_W'(mbrs_pkg::FRM_DEPTH)) begin
                  n.ovf = 1'b1; // framing or overrun spoils the whole packet
               end else begin
                  n.fbuf[q.len[5:0]] = rx_data_i;
                  n.len = q.len + 1'b1;
                  n.rxcrc = mbrs_pkg::crc_byte(q.rxcrc, rx_data_i);
               end
            end else if (q.len != '0 || q.ovf) begin
               if (q.gap >= dead_lim - 1'b1) begin
                  n.st = mbrs_pkg::MBRS_EXEC; // see RULE_01
               end else begin
                  n.gap = q.gap + 1'b1;
               end
            end
         end
         mbrs_pkg::MBRS_EXEC: begin
            // every outcome frees the receiver for the next packet
            n.st = mbrs_pkg::MBRS_WAIT; // see RULE_03
            n.len = '0;
            n.ovf = 1'b0;
            n.gap = '0;
            n.rxcrc = mbrs_pkg::CRC_INIT;
            n.txcrc = mbrs_pkg::CRC_INIT;
            n.opos = 3'h0;
            n.rdm = 1'b0;
            n.ob[0] = fa;
            n.ob[1] = ff;
            n.ob[2] = q.fbuf[2];
            n.ob[3] = q.fbuf[3];
            n.ob[4] = q.fbuf[4];
            n.ob[5] = q.fbuf[5];
            n.olen = 3'h6;
            n.ridx = idx;
            n.rleft = val[7:0];
            if (is_comm && !q.sw_s2) begin
               fmt_ok = 1'b1;
               exc = 1'b1;
               ecode = mbrs_pkg::EXC_SWITCH; // see RULE_20
            end else begin
               case (ff) // see RULE_08
                  mbrs_pkg::FN_READ: begin
                     fmt_ok = (q.len == mbrs_pkg::LEN_FIXED); // see RULE_11
                     exc = is_comm ? !(idx == mbrs_pkg::COMM_READ && val == 16'h0001)
                        : (val == 16'h0000 || val > mbrs_pkg::MAX_READ_CNT
                        || idx > mbrs_pkg::RD_LAST || last > mbrs_pkg::RD_LAST); // see RULE_10
                     n.ob[2] = {val[6:0], 1'b0}; // see RULE_12
                     n.olen = 3'h3;
                     n.rdm = 1'b1;
                  end
                  mbrs_pkg::FN_CLEAR: begin
                     fmt_ok = (q.len == mbrs_pkg::LEN_FIXED);
                     exc = is_comm || idx < mbrs_pkg::CLR_FIRST || idx > mbrs_pkg::CLR_LAST
                        || (val != mbrs_pkg::CLR_ON && val != mbrs_pkg::CLR_OFF); // see RULE_15
                     n.clr_stb = good && fmt_ok && !exc && val == mbrs_pkg::CLR_ON; // see RULE_13
                     n.clr_idx = idx; // zero value is echoed but changes nothing, see RULE_14
                  end
                  mbrs_pkg::FN_WRITE1: begin
                     fmt_ok = (q.len == mbrs_pkg::LEN_FIXED);
                     exc = is_comm ? !(idx == mbrs_pkg::COMM_DEFAULTS // see RULE_17
                        || idx == mbrs_pkg::COMM_ASSIGN)
                        : !(idx <= mbrs_pkg::SETUP_LAST || idx <= mbrs_pkg::SET_LAST
                        || (idx >= mbrs_pkg::HTR_FIRST && idx <= mbrs_pkg::HTR_LAST));
                     n.wr_stb = good && fmt_ok && !exc;
                     n.wr_idx = idx;
                     n.wr_data = val;
                  end
                  mbrs_pkg::FN_WRITEN: begin
                     fmt_ok = q.len >= mbrs_pkg::LEN_MULTI_HDR
                        && !q.fbuf[6][7] && q.len == mbrs_pkg::LEN_MULTI_HDR + q.fbuf[6][6:0]
                        && {8'h00, q.fbuf[6]} == {val[14:0], 1'b0} && val != 16'h0000;
                     exc = is_comm // see RULE_22
                        || !((idx >= mbrs_pkg::SET_FIRST && last <= mbrs_pkg::SET_LAST)
                        || (idx >= mbrs_pkg::HTR_FIRST && last <= mbrs_pkg::HTR_LAST));
                     n.k = mbrs_pkg::POS_MULTI_DATA;
                  end
                  default: begin
                     fmt_ok = 1'b1;
                     exc = 1'b1; // see RULE_19
                  end
               endcase
               if (exc && ecode != mbrs_pkg::EXC_SWITCH && ff != mbrs_pkg::FN_READ
                  && ff != mbrs_pkg::FN_CLEAR && ff != mbrs_pkg::FN_WRITE1
                  && ff != mbrs_pkg::FN_WRITEN) begin
                  ecode = mbrs_pkg::EXC_FUNC;
               end else begin
                  ecode = mbrs_pkg::EXC_INDEX;
               end
            end
            if (exc) begin
               n.ob[1] = ff | mbrs_pkg::FN_EXC_BIT; // see RULE_19
               n.ob[2] = ecode; // see RULE_20
               n.olen = 3'h3;
               n.rdm = 1'b0;
            end
            // malformed or foreign packets are dropped without a reply
            if (good && fmt_ok) begin
               n.st = (ff == mbrs_pkg::FN_WRITEN && !exc) ? mbrs_pkg::MBRS_WRITE
                  : mbrs_pkg::MBRS_HDR; // see RULE_24
            end
         end
         mbrs_pkg::MBRS_WRITE: begin
            n.wr_stb = 1'b1;
            n.wr_idx = q.ridx;
            n.wr_data = {q.fbuf[q.k[5:0]], q.fbuf[q.k[5:0] + 6'h01]};
            n.k = q.k + 7'h02;
            n.ridx = q.ridx + 16'h0001;
            n.rleft = q.rleft - 8'h01;
            if (q.rleft == 8'h01) begin
               n.st = mbrs_pkg::MBRS_HDR;
            end
         end
         mbrs_pkg::MBRS_HDR: begin
            // header echoes index and value for 05 and 06, see RULE_16, RULE_18
            pbyte = q.ob[q.opos];
            push = 1'b1; // bytes go out back to back, see RULE_02
            if (fifo_ready) begin
               n.txcrc = mbrs_pkg::crc_byte(q.txcrc, pbyte);
               n.opos = q.opos + 3'h1;
               if (q.opos == q.olen - 3'h1) begin
                  n.opos = 3'h0;
                  n.st = q.rdm ? mbrs_pkg::MBRS_RDREQ : mbrs_pkg::MBRS_CRC;
                  n.hi = 1'b1;
               end
            end
         end
         mbrs_pkg::MBRS_RDREQ: begin
            n.rd_idx = q.ridx; // data must be valid the cycle after
            n.st = mbrs_pkg::MBRS_RDDAT;
         end
         mbrs_pkg::MBRS_RDDAT: begin
            pbyte = q.hi ? rd_data_i[15:8] : rd_data_i[7:0]; // see RULE_09
            push = 1'b1;
            if (fifo_ready) begin
               n.txcrc = mbrs_pkg::crc_byte(q.txcrc, pbyte);
               n.hi = !q.hi;
               if (!q.hi) begin
                  n.ridx = q.ridx + 16'h0001;
                  n.rleft = q.rleft - 8'h01;
                  n.st = (q.rleft == 8'h01) ? mbrs_pkg::MBRS_CRC : mbrs_pkg::MBRS_RDREQ;
               end
            end
         end
         mbrs_pkg::MBRS_CRC: begin
            pbyte = (q.opos == 3'h0) ? q.txcrc[7:0] : q.txcrc[15:8]; // see RULE_23
            push = 1'b1;
            if (fifo_ready) begin
               n.opos = (q.opos == 3'h0) ? 3'h1 : 3'h0;
               if (q.opos != 3'h0) begin
                  n.st = mbrs_pkg::MBRS_WAIT;
               end
            end
         end
         default: n.st = mbrs_pkg::MBRS_WAIT;
      endcase
      // registered so the busy pin never glitches while the state decodes
      n.busy = (n.st != mbrs_pkg::MBRS_WAIT);
   end

   ////////////////////////////////////////////////////////////////////////////
   // single state register
   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q <= '0;
         q.rxcrc <= mbrs_pkg::CRC_INIT;
         q.txcrc <= mbrs_pkg::CRC_INIT;
      end else begin
         q <= n;
      end
   end

   // the fifo absorbs a stalled transmitter so the emitter simply waits
   mbrs_fifo #(
      .W(8),
      .D(mbrs_pkg::TX_FIFO_DEPTH)
   ) u_txq (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .in_valid_i(push),
      .in_ready_o(fifo_ready),
      .in_data_i(pbyte),
      .out_valid_o(tx_valid_o),
      .out_ready_i(tx_ready_i),
      .out_data_o(tx_data_o)
   );

   assign rd_idx_o = q.rd_idx;
   assign wr_stb_o = q.wr_stb;
   assign wr_idx_o = q.wr_idx;
   assign wr_data_o = q.wr_data;
   assign clr_stb_o = q.clr_stb;
   assign clr_idx_o = q.clr_idx;
   assign busy_o = q.busy;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   sequence s_rd_req;
      q.st == mbrs_pkg::MBRS_RDREQ;
   endsequence
   sequence s_rd_dat;
      q.st == mbrs_pkg::MBRS_RDDAT && q.rd_idx == $past(q.ridx);
   endsequence

   AST_DEAD_END: assert property ( // see RULE_01
      (q.st == mbrs_pkg::MBRS_WAIT && q.len != '0 && !rx_valid_i && q.gap >= dead_lim - 1'b1)
      |=> q.st == mbrs_pkg::MBRS_EXEC) else $error("packet not closed at dead time");
   AST_NO_EARLY_REPLY: assert property ( // see RULE_24
      q.st == mbrs_pkg::MBRS_WAIT ##1 q.st != mbrs_pkg::MBRS_WAIT
      |-> q.st == mbrs_pkg::MBRS_EXEC) else $error("reply began before validation");
   AST_CRC_DROP: assert property ( // see RULE_06
      (q.st == mbrs_pkg::MBRS_EXEC && q.rxcrc != 16'h0000)
      |=> q.st == mbrs_pkg::MBRS_WAIT && !q.wr_stb && !q.clr_stb)
      else $error("crc error packet acted upon");
   AST_FOREIGN_DROP: assert property ( // see RULE_04
      (q.st == mbrs_pkg::MBRS_EXEC && fa != module_num_i && !is_comm)
      |=> q.st == mbrs_pkg::MBRS_WAIT) else $error("answered a foreign address");
   AST_CLEAR_ON: assert property ( // see RULE_13
      (q.st == mbrs_pkg::MBRS_EXEC && good && !is_comm && ff == mbrs_pkg::FN_CLEAR
      && q.len == mbrs_pkg::LEN_FIXED && idx >= mbrs_pkg::CLR_FIRST
      && idx <= mbrs_pkg::CLR_LAST && val == mbrs_pkg::CLR_ON)
      |=> q.clr_stb && q.clr_idx == $past(idx) ##1 !q.clr_stb) else $error("reset not issued");
   AST_CLEAR_OFF: assert property ( // see RULE_14
      (q.st == mbrs_pkg::MBRS_EXEC && ff == mbrs_pkg::FN_CLEAR && val == mbrs_pkg::CLR_OFF)
      |=> !q.clr_stb) else $error("zero value caused a reset");
   AST_BAD_FUNC: assert property ( // see RULE_19
      (q.st == mbrs_pkg::MBRS_EXEC && good && !is_comm && ff == 8'h04)
      |=> q.st == mbrs_pkg::MBRS_HDR && q.ob[1] == 8'h84 && q.ob[2] == mbrs_pkg::EXC_FUNC
      && q.olen == 3'h3) else $error("unsupported function not refused");
   AST_WRITE_RANGE: assert property ( // see RULE_17
      q.wr_stb |-> q.wr_idx <= mbrs_pkg::SET_LAST || q.wr_idx == mbrs_pkg::COMM_DEFAULTS
      || q.wr_idx == mbrs_pkg::COMM_ASSIGN
      || (q.wr_idx >= mbrs_pkg::HTR_FIRST && q.wr_idx <= mbrs_pkg::HTR_LAST))
      else $error("write outside writable ranges");
   AST_READ_STEP: assert property ( // see RULE_09
      s_rd_req |=> s_rd_dat) else $error("register fetch out of step");
endmodule // mbrs_slave

// *** inc/mbrs_pkg.sv ***
package mbrs_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // timing: dead time is 3.5 ten-bit characters at the selected baud rate
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned CHAR_BITS = 10;
   localparam int unsigned DEAD_HALF_CHARS = 7;
   localparam int unsigned DEAD_BITS = DEAD_HALF_CHARS * CHAR_BITS / 2;
   localparam int unsigned BAUD_1200 = 1200;
   localparam int unsigned BAUD_2400 = 2400;
   localparam int unsigned BAUD_4800 = 4800;
   localparam int unsigned BAUD_9600 = 9600;

   // least time, so round up to whole cycles
   function automatic int unsigned dead_cycles(input int unsigned baud);
      return (DEAD_BITS * CLK_HZ + baud - 1) / baud;
   endfunction

   localparam int unsigned DEAD_1200 = dead_cycles(BAUD_1200);
   localparam int unsigned DEAD_2400 = dead_cycles(BAUD_2400);
   localparam int unsigned DEAD_4800 = dead_cycles(BAUD_4800);
   localparam int unsigned DEAD_9600 = dead_cycles(BAUD_9600);
   localparam int unsigned GAP_W = 21;
   localparam logic [1:0] BSEL_1200 = 2'h0;
   localparam logic [1:0] BSEL_2400 = 2'h1;
   localparam logic [1:0] BSEL_4800 = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // frame storage and layout
   localparam int unsigned FRM_DEPTH = 64;
   localparam int unsigned LEN_W = 7;
   localparam logic [6:0] LEN_MIN = 7'h04;
   localparam logic [6:0] LEN_FIXED = 7'h08;
   localparam logic [6:0] LEN_MULTI_HDR = 7'h09;
   localparam logic [6:0] POS_MULTI_DATA = 7'h07;
   localparam int unsigned TX_FIFO_DEPTH = 16;

   ////////////////////////////////////////////////////////////////////////////
   // addresses, functions, exceptions
   localparam logic [7:0] ADDR_MIN = 8'h01;
   localparam logic [7:0] ADDR_MAX = 8'hFA;
   localparam logic [7:0] ADDR_COMM = 8'hFF;
   localparam logic [7:0] FN_READ = 8'h03;
   localparam logic [7:0] FN_CLEAR = 8'h05;
   localparam logic [7:0] FN_WRITE1 = 8'h06;
   localparam logic [7:0] FN_WRITEN = 8'h10;
   localparam logic [7:0] FN_EXC_BIT = 8'h80;
   localparam logic [7:0] EXC_FUNC = 8'h01;
   localparam logic [7:0] EXC_INDEX = 8'h02;
   localparam logic [7:0] EXC_SWITCH = 8'h08;

   ////////////////////////////////////////////////////////////////////////////
   // index ranges and values
   localparam logic [15:0] MAX_READ_CNT = 16'h007D;
   localparam logic [15:0] RD_LAST = 16'h00A4;
   localparam logic [15:0] CLR_FIRST = 16'h00A5;
   localparam logic [15:0] CLR_LAST = 16'h00BA;
   localparam logic [15:0] CLR_ON = 16'hFF00;
   localparam logic [15:0] CLR_OFF = 16'h0000;
   localparam logic [15:0] SETUP_LAST = 16'h001E;
   localparam logic [15:0] SET_FIRST = 16'h001F;
   localparam logic [15:0] SET_LAST = 16'h002B;
   localparam logic [15:0] HTR_FIRST = 16'h0047;
   localparam logic [15:0] HTR_LAST = 16'h006C;
   localparam logic [15:0] COMM_DEFAULTS = 16'h00BB;
   localparam logic [15:0] COMM_READ = 16'h00BC;
   localparam logic [15:0] COMM_ASSIGN = 16'h00BD;
   localparam logic [15:0] CRC_INIT = 16'hFFFF;
   localparam logic [15:0] CRC_POLY = 16'hA001;

   typedef enum logic [2:0] {
      MBRS_WAIT  = 3'h0,
      MBRS_EXEC  = 3'h1,
      MBRS_WRITE = 3'h2,
      MBRS_HDR   = 3'h3,
      MBRS_RDREQ = 3'h4,
      MBRS_RDDAT = 3'h5,
      MBRS_CRC   = 3'h6
   } mbrs_state_t;

   // reflected crc-16, one byte, lsb first
   function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction

endpackage

// *** rtl/mbrs_fifo.sv ***
module mbrs_fifo #(
   parameter int unsigned W = 8,
   parameter int unsigned D = 16
) (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   localparam int unsigned AW = $clog2(D);

   typedef struct packed {
      logic [D-1:0][W-1:0] mem;
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } mbrs_fifo_t;

   mbrs_fifo_t q, n;
   logic push, pop;

   ////////////////////////////////////////////////////////////////////////////
   // honest full/empty from the fill count
   always_comb begin
      n = q;
      push = in_valid_i && (q.cnt != D[AW:0]);
      pop = out_ready_i && (q.cnt != '0);
      if (push) begin
         n.mem[q.wp] = in_data_i;
         n.wp = q.wp + 1'b1;
      end
      if (pop) begin
         n.rp = q.rp + 1'b1;
      end
      n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign in_ready_o = (q.cnt != D[AW:0]);
   assign out_valid_o = (q.cnt != '0);
   assign out_data_o = q.mem[q.rp];

   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);

   AST_FIFO_NO_OVERFILL: assert property (q.cnt == D[AW:0] |-> !in_ready_o ##1 q.cnt <= D[AW:0])
      else $error("fifo accepted a word while full");
endmodule // mbrs_fifo

// *** dv/mbrs_master.sv ***
// bus master model: sends request bytes, takes reply bytes with random stalls
module mbrs_master (
   input wire logic sys_clk_i,
   output logic [7:0] rx_data_o,
   output logic rx_valid_o,
   input wire logic tx_valid_i,
   output logic tx_ready_o
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      rx_data_o = 8'h00;
      rx_valid_o = 1'b0;
      tx_ready_o = 1'b0;
   end
   // the uart stalls now and then, so the reply path sees back-pressure
   always @(posedge sys_clk_i) begin
      tx_ready_o <= #2 ($urandom_range(3) != 0);
   end
   ////////////////////////////////////////////////////////////////////////////
   // one byte per pulse, gaps of 1..3 idle cycles, far below the dead time
   task automatic send(input logic [7:0] b[$]);
      foreach (b[i]) begin
         @(posedge sys_clk_i);
         #2;
         rx_data_o = b[i];
         rx_valid_o = 1'b1;
         @(posedge sys_clk_i);
         #2;
         rx_valid_o = 1'b0;
         rx_data_o = ~b[i]; // stale data must not look valid
         repeat ($urandom_range(2)) @(posedge sys_clk_i);
      end
   endtask
endmodule // mbrs_master

// *** dv/tb.sv ***
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int DL = 50; // short dead time keeps the run brief
   logic sys_clk_i, rst_i, addr_en, rx_err, rx_valid, tx_valid, tx_ready, wr_stb, clr_stb, busy;
   logic [7:0] mod_num, rx_data, tx_data, a;
   logic [1:0] bsel;
   logic [15:0] rd_idx, rd_data, wr_idx, wr_data, clr_idx, v;
   logic [7:0] exp_q[$];
   logic [32:0] stb_q[$];
   int failures, checked, tn;
   assign rd_data = rd_idx ^ 16'h5A00; // register file stand-in
   mbrs_slave #(.DEAD_1200_CYC(DL), .DEAD_2400_CYC(DL), .DEAD_4800_CYC(DL),
      .DEAD_9600_CYC(DL)) dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .module_num_i(mod_num),
      .addr_en_pin_i(addr_en), .baud_sel_i(bsel), .rx_data_i(rx_data), .rx_valid_i(rx_valid),
      .rx_err_i(rx_err), .tx_data_o(tx_data), .tx_valid_o(tx_valid), .tx_ready_i(tx_ready),
      .rd_idx_o(rd_idx), .rd_data_i(rd_data), .wr_stb_o(wr_stb), .wr_idx_o(wr_idx),
      .wr_data_o(wr_data), .clr_stb_o(clr_stb), .clr_idx_o(clr_idx), .busy_o(busy));
   mbrs_master m (.sys_clk_i(sys_clk_i), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
      .tx_valid_i(tx_valid), .tx_ready_o(tx_ready));
   initial begin
      sys_clk_i = 1'b0;
      forever #12.5 sys_clk_i = ~sys_clk_i;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [32:0] e, input logic [32:0] s);
      checked++;
      if (e !== s) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, e, s);
      end
   endtask
   task automatic close_out();
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // crc-16 reflected, computed independently of the design
   function automatic logic [15:0] crc16(input logic [7:0] q[$]);
      logic [15:0] c;
      c = mbrs_pkg::CRC_INIT;
      foreach (q[i]) begin
         c = c ^ {8'h00, q[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? ((c >> 1) ^ mbrs_pkg::CRC_POLY) : (c >> 1);
      end
      return c;
   endfunction
   // monitor: every reply byte and strobe takes the oldest note off its queue;
   // looked at mid-cycle so flop outputs are settled, not racing the edge
   always @(negedge sys_clk_i) begin
      if (tx_valid && tx_ready)
         chk("tx byte", exp_q.size() ? {25'h0, exp_q.pop_front()} : 33'h1FFFFFFFF,
            {25'h0, tx_data});
      if (wr_stb || clr_stb)
         chk("strobe", stb_q.size() ? stb_q.pop_front() : 33'h1FFFFFFFF,
            wr_stb ? {1'b0, wr_idx, wr_data} : {1'b1, clr_idx, 16'h0000});
   end
   ////////////////////////////////////////////////////////////////////////////
   // one request; a nonempty reply gets its crc, low byte first
   task automatic run(input logic [7:0] rq[$], input logic [7:0] rs[$], input bit bad);
      logic [15:0] c;
      int n;
      c = crc16(rq);
      rq.push_back(c[7:0] ^ {7'h00, bad});
      rq.push_back(c[15:8]);
      if (rs.size() != 0) begin
         c = crc16(rs);
         rs.push_back(c[7:0]);
         rs.push_back(c[15:8]);
      end
      foreach (rs[i]) exp_q.push_back(rs[i]);
      m.send(rq);
      repeat (DL - 5) @(posedge sys_clk_i);
      #1;
      chk("busy before dead time", 33'h0, {32'h0, busy});
      n = 0;
      while ((busy || exp_q.size() != 0 || n < 10) && n < 2000) begin
         @(posedge sys_clk_i);
         #1;
         n++;
      end
      chk("reply bytes left", 33'h0, 33'(exp_q.size()));
      chk("strobes left", 33'h0, 33'(stb_q.size()));
      tn++;
      $display("test %0d done", tn);
   endtask
   initial begin
      #(25 * 40000);
      failures++;
      close_out();
   end
   initial begin
      void'($urandom(32'h3737FC39));
      rst_i = 1'b1;
      addr_en = 1'b0;
      rx_err = 1'b0;
      bsel = 2'h0;
      mod_num = 8'($urandom_range(250, 1));
      a = mod_num;
      v = 16'($urandom);
      repeat (4) @(posedge sys_clk_i);
      #2;
      rst_i = 1'b0;
      bsel = 2'($urandom_range(3));
      repeat (4) @(posedge sys_clk_i);
      run('{a, 8'h03, 8'h00, 8'h49, 8'h00, 8'h02},
         '{a, 8'h03, 8'h04, 8'h5A, 8'h49, 8'h5A, 8'h4A}, 0);
      run('{a, 8'h03, 8'h00, 8'hA4, 8'h00, 8'h01},
         '{a, 8'h03, 8'h02, 8'h5A, 8'hA4}, 0);
      run('{a, 8'h03, 8'h00, 8'hA4, 8'h00, 8'h02}, '{a, 8'h83, 8'h02}, 0);
      stb_q.push_back({1'b1, 16'h00A5, 16'h0000});
      run('{a, 8'h05, 8'h00, 8'hA5, 8'hFF, 8'h00},
         '{a, 8'h05, 8'h00, 8'hA5, 8'hFF, 8'h00}, 0);
      run('{a, 8'h05, 8'h00, 8'hBA, 8'h00, 8'h00},
         '{a, 8'h05, 8'h00, 8'hBA, 8'h00, 8'h00}, 0);
      run('{a, 8'h05, 8'h00, 8'hB0, 8'h12, 8'h34}, '{a, 8'h85, 8'h02}, 0);
      run('{a, 8'h05, 8'h00, 8'hBB, 8'hFF, 8'h00}, '{a, 8'h85, 8'h02}, 0);
      stb_q.push_back({1'b0, 16'h0048, v});
      run('{a, 8'h06, 8'h00, 8'h48, v[15:8], v[7:0]},
         '{a, 8'h06, 8'h00, 8'h48, v[15:8], v[7:0]}, 0);
      run('{a, 8'h06, 8'h00, 8'h2C, 8'h00, 8'h01}, '{a, 8'h86, 8'h02}, 0);
      stb_q.push_back({1'b0, 16'h0049, 16'h0032});
      stb_q.push_back({1'b0, 16'h004A, 16'h0BB8});
      run('{a, 8'h10, 8'h00, 8'h49, 8'h00, 8'h02, 8'h04, 8'h00, 8'h32, 8'h0B, 8'hB8},
         '{a, 8'h10, 8'h00, 8'h49, 8'h00, 8'h02}, 0);
      run('{a, 8'h10, 8'h00, 8'h1E, 8'h00, 8'h01, 8'h02, 8'h00, 8'h01},
         '{a, 8'h90, 8'h02}, 0);
      run('{a, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, '{a, 8'h84, 8'h01}, 0);
      run('{a ^ 8'h01, 8'h06, 8'h00, 8'h48, 8'h00, 8'h01}, '{}, 0);
      run('{a, 8'h06, 8'h00, 8'h48, 8'h00, 8'h01}, '{}, 1);
      run('{8'hFF, 8'h06, 8'h00, 8'hBD, 8'h00, 8'hE6}, '{8'hFF, 8'h86, 8'h08}, 0);
      #1 addr_en = 1'b1;
      repeat (4) @(posedge sys_clk_i);
      run('{8'hFF, 8'h03, 8'h00, 8'hBC, 8'h00, 8'h01},
         '{8'hFF, 8'h03, 8'h02, 8'h5A, 8'hBC}, 0);
      // a framing error on every byte spoils the packet: no reply, no strobe
      #1 rx_err = 1'b1;
      run('{a, 8'h06, 8'h00, 8'h48, 8'h00, 8'h01}, '{}, 0);
      #1 rx_err = 1'b0;
      close_out();
   end
endmodule // tb
